// file: logic/cmsc_pkg.sv
// Package of constants and types for the clock mode and sync control block
// Notes on behaviour
// - Sync from pin toggle or polarity bit toggle
// - Sync event becomes internal one-shot pulse
// - Wait two qualifying falling edges before pulse
// - Outputs forced low five cycles after pulse start
// - Outputs rise five plus delay cycles after pulse
// - Zero-delay mode feeds selected output to loop counter
// - Feedback mux picks even group output or external
// - Feedback output may sleep if group not down
// - Five-bit mode field selects operating mode
// - Dual loop takes reference from either input
// - Holdover freezes first loop tuning on reference loss
// - Auto sync on latch-enable fall after divider write
package cmsc_pkg;

  // ************************************************************
  // Counts and widths
  // ************************************************************
  localparam int          CMSC_GROUPS      = 6;
  localparam int          CMSC_DLY_W       = 5;
  localparam logic [3:0]  CMSC_FORCE_LOW_CYC = 4'h5;
  localparam logic [3:0]  CMSC_RISE_BASE_CYC = 4'h5;
  localparam logic [3:0]  CMSC_PULSE_CYC   = 4'h2;
  localparam logic [2:0]  CMSC_FB_EXTERNAL = 3'h6;

  // ************************************************************
  // Mode codes
  // ************************************************************
  localparam logic [4:0]  CMSC_MODE_DUAL_INT    = 5'h00;
  localparam logic [4:0]  CMSC_MODE_ZD_DUAL_INT = 5'h02;
  localparam logic [4:0]  CMSC_MODE_DUAL_EXT    = 5'h03;
  localparam logic [4:0]  CMSC_MODE_ZD_DUAL_EXT = 5'h05;
  localparam logic [4:0]  CMSC_MODE_SGL_INT     = 5'h06;
  localparam logic [4:0]  CMSC_MODE_ZD_SGL_INT  = 5'h08;
  localparam logic [4:0]  CMSC_MODE_SGL_EXT     = 5'h0b;
  localparam logic [4:0]  CMSC_MODE_DIST        = 5'h10;

  typedef struct packed {
    logic first_loop_on;
    logic second_loop_on;
    logic ext_oscillator;
    logic zero_delay;
    logic valid;
  } cmsc_mode_t;

  typedef enum logic [2:0] {
    CMSC_IDLE     = 3'b000,
    CMSC_QUAL1    = 3'b001,
    CMSC_QUAL2    = 3'b010,
    CMSC_PULSE    = 3'b011,
    CMSC_HOLD_LOW = 3'b100
  } cmsc_state_t;

  function automatic cmsc_mode_t cmsc_decode_mode(input logic [4:0] m);
    cmsc_mode_t r;
    r = '0;
    r.valid = 1'b1;
    case (m)
      CMSC_MODE_DUAL_INT:    r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
      CMSC_MODE_ZD_DUAL_INT: r = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      CMSC_MODE_DUAL_EXT:    r = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      CMSC_MODE_ZD_DUAL_EXT: r = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      CMSC_MODE_SGL_INT:     r = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      CMSC_MODE_ZD_SGL_INT:  r = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
      CMSC_MODE_SGL_EXT:     r = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      CMSC_MODE_DIST:        r = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      default:               r = '0;
    endcase
    return r;
  endfunction

endpackage

// file: logic/cmsc_top.sv
// Clock mode selection, feedback mux and dynamic delay sync sequencer
module cmsc_top
  import cmsc_pkg::*;
#(
  parameter int GROUPS = CMSC_GROUPS,
  parameter int DLY_W  = CMSC_DLY_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [4:0]        mode_select,
  input  wire logic              sync_pin,
  input  wire logic              sync_polarity_invert,
  input  wire logic              sync_enable,
  input  wire logic              sync_auto_enable,
  input  wire logic              divider_written,
  input  wire logic              latch_enable,
  input  wire logic              sync_qualify_select,
  input  wire logic              qual_clock,
  input  wire logic [DLY_W-1:0]  digital_delay_count,
  input  wire logic              half_step_bit,
  input  wire logic              feedback_mux_enable,
  input  wire logic [2:0]        feedback_select,
  input  wire logic [GROUPS-1:0] even_clock_output,
  input  wire logic [GROUPS-1:0] group_power_down,
  input  wire logic              external_feedback_input,
  input  wire logic              reference_select,
  input  wire logic [1:0]        reference_input,
  input  wire logic              reference_lost,
  input  wire logic              holdover_enable,
  output logic                   first_loop_feedback,
  output logic                   first_loop_reference,
  output logic                   second_loop_feedback_zd,
  output logic                   first_loop_enable,
  output logic                   second_loop_enable,
  output logic                   ext_oscillator_mode,
  output logic                   zero_delay_mode,
  output logic                   mode_invalid,
  output logic                   tuning_hold,
  output logic                   one_shot,
  output logic                   outputs_forced_low,
  output logic                   half_step_shift,
  output logic                   sync_busy
);

  // ************************************************************
  // Mode and feedback selection
  // ************************************************************
  wire cmsc_mode_t mode_dec = cmsc_decode_mode(mode_select);
  wire             fb_ext   = (feedback_select == CMSC_FB_EXTERNAL);
  wire             fb_idx_ok = (feedback_select < 3'(GROUPS));
  // Group power-down gates the even output even if the output buffer sleeps
  wire             fb_int_clk = fb_idx_ok && !group_power_down[feedback_select]
                                && even_clock_output[feedback_select];
  wire             fb_mux_out = !feedback_mux_enable ? 1'b0 :
                                fb_ext ? external_feedback_input : fb_int_clk;
  wire             zd_first  = mode_dec.zero_delay && mode_dec.first_loop_on;
  wire             zd_second = mode_dec.zero_delay && !mode_dec.first_loop_on;
  wire             ref_mux   = reference_input[reference_select];

  // ************************************************************
  // Sync event sources
  // ************************************************************
  logic pin_reg;
  logic pol_reg;
  logic le_reg;
  logic qual_reg;
  wire  pin_toggle  = pin_reg != sync_pin;
  wire  pol_toggle  = pol_reg != sync_polarity_invert;
  wire  le_fall     = le_reg && !latch_enable;
  wire  auto_event  = sync_auto_enable && divider_written && le_fall;
  wire  sync_event  = sync_enable && (pin_toggle || pol_toggle || auto_event);
  wire  qual_fall   = qual_reg && !qual_clock;
  // Without qualification the free-running clock edge stands in
  wire  qual_edge   = sync_qualify_select ? qual_fall : 1'b1;

  // ************************************************************
  // One-shot sequencer
  // ************************************************************
  cmsc_state_t      state_reg;
  cmsc_state_t      state_next;
  logic [7:0]       cnt_reg;
  logic [7:0]       cnt_next;
  logic             low_reg;
  logic             low_next;
  logic [7:0]       since_start_reg;
  logic [7:0]       since_start_next;
  logic [DLY_W-1:0] dly_reg;
  logic             pend_reg;
  wire  [7:0]       rise_cyc = 8'(CMSC_RISE_BASE_CYC) + 8'(dly_reg);

  always_comb begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    low_next         = low_reg;
    since_start_next = since_start_reg;
    case (state_reg)
      CMSC_IDLE: begin
        if (pend_reg || sync_event) begin
          state_next = CMSC_QUAL1;
        end
      end
      CMSC_QUAL1: begin
        if (qual_edge) begin
          state_next = CMSC_QUAL2;
        end
      end
      CMSC_QUAL2: begin
        if (qual_edge) begin
          state_next       = CMSC_PULSE;
          cnt_next         = 8'h00;
          since_start_next = 8'h00;
        end
      end
      CMSC_PULSE: begin
        since_start_next = since_start_reg + 8'h01;
        cnt_next         = cnt_reg + 8'h01;
        if (since_start_reg + 8'h01 == 8'(CMSC_FORCE_LOW_CYC)) begin
          low_next = 1'b1;
        end
        if (cnt_reg + 8'h01 == 8'(CMSC_PULSE_CYC)) begin
          state_next = CMSC_HOLD_LOW;
          cnt_next   = 8'h00;
        end
      end
      CMSC_HOLD_LOW: begin
        since_start_next = since_start_reg + 8'h01;
        cnt_next         = cnt_reg + 8'h01;
        if (since_start_reg + 8'h01 == 8'(CMSC_FORCE_LOW_CYC)) begin
          low_next = 1'b1;
        end
        if (cnt_reg + 8'h01 >= rise_cyc) begin
          low_next   = 1'b0;
          state_next = CMSC_IDLE;
        end
      end
      default: begin
        state_next = CMSC_IDLE;
        low_next   = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg       <= CMSC_IDLE;
      cnt_reg         <= 8'h00;
      low_reg         <= 1'b0;
      since_start_reg <= 8'h00;
      dly_reg         <= '0;
      pend_reg        <= 1'b0;
      pin_reg         <= 1'b0;
      pol_reg         <= 1'b0;
      le_reg          <= 1'b0;
      qual_reg        <= 1'b0;
    end else if (ce) begin
      state_reg       <= state_next;
      cnt_reg         <= cnt_next;
      low_reg         <= low_next;
      since_start_reg <= since_start_next;
      pin_reg         <= sync_pin;
      pol_reg         <= sync_polarity_invert;
      le_reg          <= latch_enable;
      qual_reg        <= qual_clock;
      // Delay is captured at pulse start so later writes only prepare the next sync
      if (state_reg == CMSC_QUAL2 && state_next == CMSC_PULSE) begin
        dly_reg <= digital_delay_count;
      end
      // An event during a running sequence is held, set wins over consume
      if (sync_event && state_reg != CMSC_IDLE) begin
        pend_reg <= 1'b1;
      end else if (state_reg == CMSC_IDLE) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      first_loop_feedback     <= 1'b0;
      first_loop_reference    <= 1'b0;
      second_loop_feedback_zd <= 1'b0;
      first_loop_enable       <= 1'b0;
      second_loop_enable      <= 1'b0;
      ext_oscillator_mode     <= 1'b0;
      zero_delay_mode         <= 1'b0;
      mode_invalid            <= 1'b0;
      tuning_hold             <= 1'b0;
      half_step_shift         <= 1'b0;
    end else if (ce) begin
      first_loop_feedback     <= zd_first ? fb_mux_out : 1'b0;
      second_loop_feedback_zd <= zd_second ? fb_mux_out : 1'b0;
      first_loop_reference    <= mode_dec.first_loop_on ? ref_mux : 1'b0;
      first_loop_enable       <= mode_dec.first_loop_on;
      second_loop_enable      <= mode_dec.second_loop_on;
      ext_oscillator_mode     <= mode_dec.ext_oscillator;
      zero_delay_mode         <= mode_dec.zero_delay;
      mode_invalid            <= !mode_dec.valid;
      tuning_hold             <= mode_dec.first_loop_on && holdover_enable && reference_lost;
      half_step_shift         <= half_step_bit;
    end
  end

  assign one_shot           = (state_reg == CMSC_PULSE);
  assign outputs_forced_low = low_reg;
  assign sync_busy          = (state_reg != CMSC_IDLE);

endmodule

// file: tb/cmsc_host.sv
// Host model: delay step sequences and sync pin toggling
module cmsc_host (
  input  wire logic clk,
  output logic      sync_pin,
  output logic      half_step_bit,
  output logic [4:0] digital_delay_count
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sync_pin = 1'b0;
    half_step_bit = 1'b0;
    digital_delay_count = 5'h05;
  end
  // One write per cycle, just after the edge
  task automatic put(input logic [4:0] d, input logic h, input logic t);
    @(posedge clk);
    #10;
    digital_delay_count = d;
    half_step_bit = h;
    sync_pin = sync_pin ^ t;
  endtask
  task automatic step(input logic fwd);
    if (fwd && !half_step_bit)
      put(digital_delay_count, 1'b1, 1'b0);
    else if (fwd) begin
      put(5'h09, 1'b1, 1'b0);
      put(5'h09, 1'b1, 1'b1);
    end else if (!half_step_bit) begin
      put(digital_delay_count, 1'b1, 1'b0);
      put(5'h05, 1'b1, 1'b0);
      put(5'h05, 1'b1, 1'b1);
    end else
      put(digital_delay_count, 1'b0, 1'b0);
  endtask
endmodule

// file: tb/cmsc_chk.sv
// Concurrent checks on sync sequencing and mode outputs
module cmsc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [4:0] mode_select,
  input wire logic [4:0] digital_delay_count,
  input wire logic       half_step_bit,
  input wire logic       holdover_enable,
  input wire logic       reference_lost,
  input wire logic       zero_delay_mode,
  input wire logic       mode_invalid,
  input wire logic       tuning_hold,
  input wire logic       one_shot,
  input wire logic       outputs_forced_low,
  input wire logic       half_step_shift,
  input wire logic       sync_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] dly_reg;
  logic [5:0] cnt_reg;
  // Cycles since the pulse, saturating so it never wraps
  always_ff @(posedge clk) begin
    // The design takes the delay in the cycle before the pulse starts
    if ($rose(one_shot))
      dly_reg <= $past(digital_delay_count);
    if (one_shot)
      cnt_reg <= '0;
    else if (cnt_reg != 6'h3f)
      cnt_reg <= cnt_reg + 6'h01;
  end
  pulse_two_a: assert property ($rose(one_shot) |=> one_shot ##1 !one_shot)
    else $error("pulse length wrong");
  qual_wait_a: assert property ($rose(one_shot) |-> $past(sync_busy) && $past(sync_busy, 2))
    else $error("pulse without qualifying wait");
  force_low_a: assert property ($rose(one_shot) |-> !outputs_forced_low [*5] ##1 outputs_forced_low)
    else $error("outputs not forced low in time");
  low_rise_a: assert property ($fell(outputs_forced_low) |-> cnt_reg == {1'b0, dly_reg} + 6'h05)
    else $error("release not at five plus delay");
  busy_low_a: assert property ($fell(sync_busy) |-> !outputs_forced_low)
    else $error("idle while forced low");
  half_step_a: assert property ($past(ce) && !$past(rst) |-> half_step_shift == $past(half_step_bit))
    else $error("half step flag wrong");
  hold_a: assert property (tuning_hold && $past(ce) |-> $past(holdover_enable && reference_lost))
    else $error("tuning hold without cause");
  zd_mode_a: assert property (zero_delay_mode && $past(ce) |-> $past(mode_select) inside {5'h02, 5'h05, 5'h08})
    else $error("zero delay in wrong mode");
  bad_mode_a: assert property (mode_invalid && $past(ce) |->
    !($past(mode_select) inside {5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0b, 5'h10}))
    else $error("valid mode flagged invalid");
  cover property ($rose(one_shot));
  cover property ($fell(outputs_forced_low));
  cover property (tuning_hold);
endmodule
bind cmsc_top cmsc_chk u_chk (.clk, .rst, .ce, .mode_select, .digital_delay_count, .half_step_bit,
  .holdover_enable, .reference_lost, .zero_delay_mode, .mode_invalid, .tuning_hold, .one_shot,
  .outputs_forced_low, .half_step_shift, .sync_busy);

// file: tb/cmsc_bench.sv
// Self-checking bench for the clock mode and sync control block
module cmsc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, ce = 1, sync_polarity_invert = 0, sync_enable = 1, sync_auto_enable = 0;
  logic divider_written = 0, latch_enable = 0, sync_qualify_select = 0, qual_clock = 0;
  logic feedback_mux_enable = 1, external_feedback_input = 0, reference_select = 0;
  logic reference_lost = 0, holdover_enable = 0, sync_pin, half_step_bit, sl;
  logic [4:0] mode_select = 0, digital_delay_count, e;
  logic [2:0] feedback_select = 0;
  logic [5:0] even_clock_output = 0, group_power_down = 0;
  logic [1:0] reference_input = 0;
  logic first_loop_feedback, first_loop_reference, second_loop_feedback_zd, first_loop_enable;
  logic second_loop_enable, ext_oscillator_mode, zero_delay_mode, mode_invalid, tuning_hold;
  logic one_shot, outputs_forced_low, half_step_shift, sync_busy;
  logic [15:0] lfsr = 16'h4abc;
  int bad_count = 0, cmp_count = 0, n;
  always #50 clk = ~clk;
  cmsc_top DUT (.clk, .rst, .ce, .mode_select, .sync_pin, .sync_polarity_invert, .sync_enable,
    .sync_auto_enable, .divider_written, .latch_enable, .sync_qualify_select, .qual_clock,
    .digital_delay_count, .half_step_bit, .feedback_mux_enable, .feedback_select,
    .even_clock_output, .group_power_down, .external_feedback_input, .reference_select,
    .reference_input, .reference_lost, .holdover_enable, .first_loop_feedback,
    .first_loop_reference, .second_loop_feedback_zd, .first_loop_enable, .second_loop_enable,
    .ext_oscillator_mode, .zero_delay_mode, .mode_invalid, .tuning_hold, .one_shot,
    .outputs_forced_low, .half_step_shift, .sync_busy);
  cmsc_host HOST (.clk, .sync_pin, .half_step_bit, .digital_delay_count);
  // {first loop, second loop, ext osc, zero delay, invalid}
  function automatic logic [4:0] exp_mode(input logic [4:0] m);
    case (m)
      5'h00: return 5'h18;
      5'h02: return 5'h1a;
      5'h03: return 5'h1c;
      5'h05: return 5'h1e;
      5'h06: return 5'h08;
      5'h08: return 5'h0a;
      5'h0b: return 5'h0c;
      5'h10: return 5'h00;
      default: return 5'h01;
    endcase
  endfunction
  function automatic logic exp_fb();
    if (feedback_select == 3'h6)
      return external_feedback_input;
    return even_clock_output[feedback_select] & ~group_power_down[feedback_select];
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  // Bounded wait step; running out ends the run
  task automatic tick();
    cyc(1);
    n++;
    sl = sl | outputs_forced_low;
    if (n == 60) begin
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wait_shot(input int lo, input int hi);
    n = 0;
    while (one_shot !== 1'b1)
      tick();
    chk(8'(n >= lo && n <= hi), 8'h01);
    cyc(1);
    chk(one_shot, 1'b1);
    cyc(1);
    chk(one_shot, 1'b0);
  endtask
  task automatic settle();
    n = 0;
    sl = 1'b0;
    while (sync_busy !== 1'b0)
      tick();
    chk(sl, 1'b1);
    chk(outputs_forced_low, 1'b0);
  endtask
  initial begin
    cyc(12);
    rst = 0;
    for (int m = 0; m < 32; m++) begin
      mode_select = 5'(m);
      lfsr = lfsr_next(lfsr);
      feedback_select = lfsr[2:0] % 3'h7;
      // The zero-delay external oscillator mode (5) shares the feedback port, so keep feedback internal there
      if (m == 5 && feedback_select == 3'h6)
        feedback_select = 3'h0;
      {even_clock_output, group_power_down} = {lfsr[8:3], lfsr[15:10]};
      {external_feedback_input, reference_select, reference_input} = lfsr[12:9];
      {holdover_enable, reference_lost} = lfsr[14:13];
      e = exp_mode(5'(m));
      cyc(2);
      chk({first_loop_enable, second_loop_enable, ext_oscillator_mode, zero_delay_mode, mode_invalid}, e);
      chk(first_loop_feedback, (m == 2 || m == 5) & exp_fb());
      chk(second_loop_feedback_zd, (m == 8) & exp_fb());
      chk(first_loop_reference, e[4] & reference_input[reference_select]);
      chk(tuning_hold, e[4] & holdover_enable & reference_lost);
    end
    mode_select = 5'h00;
    HOST.step(1'b1);
    cyc(2);
    chk(half_step_shift, 1'b1);
    HOST.step(1'b1);
    wait_shot(3, 4);
    HOST.put(5'h09, 1'b0, 1'b0);
    settle();
    HOST.step(1'b0);
    wait_shot(3, 4);
    settle();
    HOST.step(1'b0);
    cyc(2);
    chk(half_step_shift, 1'b0);
    // Three toggles: one taken, the rest merge into one pending
    repeat (3) begin
      sync_polarity_invert = ~sync_polarity_invert;
      cyc(1);
    end
    wait_shot(0, 0);
    wait_shot(13, 13);
    settle();
    cyc(10);
    chk(sync_busy, 1'b0);
    {divider_written, sync_auto_enable, latch_enable} = 3'h7;
    cyc(1);
    latch_enable = 1'b0;
    wait_shot(3, 4);
    settle();
    sync_enable = 1'b0;
    sync_polarity_invert = ~sync_polarity_invert;
    cyc(8);
    chk(sync_busy, 1'b0);
    {sync_enable, sync_qualify_select, qual_clock} = 3'h7;
    sync_polarity_invert = ~sync_polarity_invert;
    cyc(6);
    chk({sync_busy, one_shot}, 8'h02);
    qual_clock = 1'b0;
    cyc(1);
    qual_clock = 1'b1;
    cyc(1);
    chk({sync_busy, one_shot}, 8'h02);
    qual_clock = 1'b0;
    wait_shot(1, 1);
    settle();
    stop_test();
  end
endmodule
